// *** hdl/svo_ctrl.sv ***
// Implementation choice: the APB register port.
`default_nettype none
module svo_ctrl
  import svo_pkg::*;
#(
  parameter int unsigned INIT_CYC = svo_pkg::INITIAL_CYCLES,
  parameter int unsigned UPD_CYC  = svo_pkg::LIVE_UPDATE_CYCLES
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [svo_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // run conditions from outside
  input  wire logic                          pump_enable,
  input  wire logic                          sysclk_present,
  // servo channel controls
  output logic      [svo_pkg::NUM_CH-1:0]    initial_active,
  output logic      [svo_pkg::NUM_LIVE-1:0]  live_active,
  output logic      [svo_pkg::NUM_LIVE-1:0]  live_update,
  output logic      [svo_pkg::NUM_CH-1:0]    correction_valid,
  // interrupt
  output logic                               irq
);
  import svo_pkg::*;

  localparam logic [CNT_W-1:0] INIT_LOAD = CNT_W'(INIT_CYC - 1);
  localparam logic [CNT_W-1:0] UPD_LOAD  = CNT_W'(UPD_CYC - 1);
  localparam int               INIT_LAST = INIT_CYC - 1;

  logic                rst_s1_r;
  logic                rst_n;
  logic [1:0]          cond_s1_r;
  logic [1:0]          cond_s2_r;
  logic                ok_run;
  logic [NUM_CH-1:0]   en_r;
  logic [NUM_CH-1:0]   en_nxt;
  logic [LEN_W-1:0]    len_r;
  logic [LEN_W-1:0]    len_nxt;
  logic [LEN_W-1:0]    live_len;
  logic [NUM_CH-1:0]   done_r;
  logic [NUM_CH-1:0]   hold_r;
  logic [IRQ_W-1:0]    irq_st_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic [IRQ_W-1:0]    irq_ev;
  logic                pready_r;
  logic                pslverr_r;
  logic [31:0]         prdata_r;
  logic                irq_r;
  logic [NUM_CH-1:0]   init_run_r;
  logic [NUM_LIVE-1:0] live_run_r;
  logic [NUM_LIVE-1:0] upd_r;
  logic [7:0]          idx;
  logic                addr_ok;
  logic                take;
  logic                wr_go;
  logic                sel_in;
  logic                sel_hp;
  logic                sel_len;
  logic                sel_ist;
  logic                sel_msk;
  logic [REG_W-1:0]    wmask;
  logic [REG_W-1:0]    wd;
  logic [REG_W-1:0]    rd_word;
  logic [NUM_CH-1:0]   start_req;
  logic [NUM_CH-1:0]   live_req;
  logic [NUM_CH-1:0]   start_acc;
  logic [NUM_CH-1:0]   fin_init;
  logic [NUM_CH-1:0]   fin_live;
  logic [NUM_CH-1:0]   upd_p;
  logic [NUM_CH-1:0]   init_run_nxt;
  logic [NUM_CH-1:0]   live_run_nxt;

  // masked single-bit write of a stored field
  function automatic logic upd_bit(input logic o, input logic s, input logic m, input logic d);
    upd_bit = (s && m) ? d : o;
  endfunction

  // reset release and condition synchronisers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cond_s1_r <= 2'h0;
      cond_s2_r <= 2'h0;
    end else begin
      cond_s1_r <= {pump_enable, sysclk_present};
      cond_s2_r <= cond_s1_r;
    end
  end
  assign ok_run = cond_s2_r[1] & cond_s2_r[0];

  // apb decode; one wait state so every answer comes from a flop
  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0) &&
                   (idx == IDX_INPUT_CTRL || idx == IDX_HP_CTRL || idx == IDX_SERIES_LEN ||
                    idx == IDX_STATUS || idx == IDX_ACTIVITY || idx == IDX_IRQ_STATUS ||
                    idx == IDX_IRQ_MASK);
  assign take    = psel && penable && !pready_r;
  assign wr_go   = psel && penable && pready_r && pwrite && addr_ok;
  assign sel_in  = wr_go && (idx == IDX_INPUT_CTRL);
  assign sel_hp  = wr_go && (idx == IDX_HP_CTRL);
  assign sel_len = wr_go && (idx == IDX_SERIES_LEN);
  assign sel_ist = wr_go && (idx == IDX_IRQ_STATUS);
  assign sel_msk = wr_go && (idx == IDX_IRQ_MASK);
  assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wd      = pwdata[REG_W-1:0] & wmask;

  assign en_nxt  = {upd_bit(en_r[3], sel_in, wmask[BIT_L_EN], pwdata[BIT_L_EN]),
                    upd_bit(en_r[2], sel_in, wmask[BIT_R_EN], pwdata[BIT_R_EN]),
                    upd_bit(en_r[1], sel_hp, wmask[BIT_L_EN], pwdata[BIT_L_EN]),
                    upd_bit(en_r[0], sel_hp, wmask[BIT_R_EN], pwdata[BIT_R_EN])};
  assign len_nxt = (sel_len && wmask[LEN_LSB + LEN_W - 1] && wmask[LEN_LSB]) ?
                   pwdata[LEN_LSB +: LEN_W] : len_r;
  // reserved short codes run as the shortest legal series
  assign live_len = (len_r < LEN_MIN) ? LEN_MIN : len_r;

  // trigger bits are never stored, they act only as pulses
  assign start_req = {sel_in & wd[BIT_L_INIT], sel_in & wd[BIT_R_INIT],
                      sel_hp & wd[BIT_L_INIT], sel_hp & wd[BIT_R_INIT]};
  // input channels have no live trigger
  assign live_req  = {2'b00, sel_hp & wd[BIT_L_LIVE], sel_hp & wd[BIT_R_LIVE]};
  // enable written in the same access counts
  assign start_acc = start_req & en_nxt & {NUM_CH{ok_run}};

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      svo_chan_state_t   st_r;
      svo_chan_state_t   st_nxt;
      logic [CNT_W-1:0]  cnt_r;
      logic [CNT_W-1:0]  cnt_nxt;
      logic [LEN_W-1:0]  left_r;
      logic [LEN_W-1:0]  left_nxt;
      logic              live_acc;
      logic              stop;
      logic              f_init;
      logic              f_live;
      logic              u_p;

      // an initial run in progress is not interrupted by a live trigger
      assign live_acc = live_req[c] && en_nxt[c] && ok_run && (st_r != CH_INITIAL);
      // disable or loss of pump/clock abandons the run, old correction stays
      assign stop     = !en_nxt[c] || !ok_run;

      always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        left_nxt = left_r;
        f_init   = 1'b0;
        f_live   = 1'b0;
        u_p      = 1'b0;
        if (start_acc[c]) begin
          st_nxt  = CH_INITIAL;
          cnt_nxt = INIT_LOAD;
        end else if (live_acc) begin
          st_nxt   = CH_LIVE;
          cnt_nxt  = UPD_LOAD;
          left_nxt = live_len - 7'h01;
        end else begin
          case (st_r)
            CH_INITIAL: begin
              if (stop) begin
                st_nxt = CH_IDLE;
              end else if (cnt_r == '0) begin
                st_nxt = CH_IDLE;
                f_init = 1'b1;
              end else begin
                cnt_nxt = cnt_r - 1'b1;
              end
            end
            CH_LIVE: begin
              if (stop) begin
                st_nxt = CH_IDLE;
              end else if (cnt_r == '0) begin
                u_p = 1'b1;
                if (left_r == '0) begin
                  st_nxt = CH_IDLE;
                  f_live = 1'b1;
                end else begin
                  left_nxt = left_r - 1'b1;
                  cnt_nxt  = UPD_LOAD;
                end
              end else begin
                cnt_nxt = cnt_r - 1'b1;
              end
            end
            default: begin
              st_nxt = CH_IDLE;
            end
          endcase
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          st_r   <= CH_IDLE;
          cnt_r  <= '0;
          left_r <= '0;
        end else begin
          st_r   <= st_nxt;
          cnt_r  <= cnt_nxt;
          left_r <= left_nxt;
        end
      end

      assign fin_init[c]     = f_init;
      assign fin_live[c]     = f_live;
      assign upd_p[c]        = u_p;
      assign init_run_nxt[c] = (st_nxt == CH_INITIAL);
      assign live_run_nxt[c] = (st_nxt == CH_LIVE);
    end
  endgenerate

  assign irq_ev = {fin_live[1:0], fin_init};
  // read mux; trigger bits read as zero
  always_comb begin
    rd_word = REG_RESET;
    case (idx)
      IDX_INPUT_CTRL: begin
        rd_word[BIT_L_EN] = en_r[3];
        rd_word[BIT_R_EN] = en_r[2];
      end
      IDX_HP_CTRL: begin
        rd_word[BIT_L_EN] = en_r[1];
        rd_word[BIT_R_EN] = en_r[0];
      end
      IDX_SERIES_LEN: rd_word[LEN_LSB +: LEN_W] = len_r;
      IDX_STATUS:     rd_word[DONE_LSB +: NUM_CH] = done_r;
      IDX_ACTIVITY:   rd_word[IRQ_W-1:0] = {live_run_r, init_run_r};
      IDX_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_st_r;
      IDX_IRQ_MASK:   rd_word[IRQ_W-1:0] = irq_mask_r;
      default:        rd_word = REG_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= take;
      pslverr_r <= take && !addr_ok;
      prdata_r  <= (take && !pwrite && addr_ok) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  // a finish in the cycle of an irq status clear write keeps the flag set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_r       <= '0;
      len_r      <= LEN_RESET;
      done_r     <= '0;
      hold_r     <= '0;
      irq_st_r   <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
      init_run_r <= '0;
      live_run_r <= '0;
      upd_r      <= '0;
    end else begin
      en_r       <= en_nxt;
      len_r      <= len_nxt;
      done_r     <= fin_init | (done_r & ~start_acc);
      hold_r     <= fin_init | fin_live | (hold_r & ~start_acc);
      irq_st_r   <= irq_ev | (irq_st_r & ~(wd[IRQ_W-1:0] & {IRQ_W{sel_ist}}));
      irq_mask_r <= sel_msk ? ((pwdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]) |
                               (irq_mask_r & ~wmask[IRQ_W-1:0])) : irq_mask_r;
      irq_r      <= |(irq_st_r & irq_mask_r);
      init_run_r <= init_run_nxt;
      live_run_r <= live_run_nxt[NUM_LIVE-1:0];
      upd_r      <= upd_p[NUM_LIVE-1:0];
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign irq              = irq_r;
  assign initial_active   = init_run_r;
  assign live_active      = live_run_r;
  assign live_update      = upd_r;
  assign correction_valid = hold_r;
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [CNT_W-1:0] age0_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      age0_r <= '0;
    end else if (start_acc[0]) begin
      age0_r <= '0;
    end else if (init_run_r[0]) begin
      age0_r <= age0_r + 1'b1;
    end
  end

  sequence s_init_accept;
    start_acc[0] ##1 initial_active[0];
  endsequence

  sequence s_live_accept;
    g_ch[0].live_acc ##1 live_active[0];
  endsequence

  chk_enable_gates_run: assert property (
    ((initial_active & ~$past(initial_active) & ~en_r) == '0))
    else $error("initial run started on a disabled channel");
  chk_initial_start: assert property (start_acc[0] |-> s_init_accept)
    else $error("initial trigger did not start a run");
  chk_done_flag_set: assert property (
    (fin_init != '0) |=> ((done_r & $past(fin_init)) == $past(fin_init)))
    else $error("completion flag not set after run");
  chk_multi_start: assert property (
    (start_acc != '0) |=> ((initial_active & $past(start_acc)) == $past(start_acc)))
    else $error("simultaneous triggers not all taken");
  chk_initial_length: assert property (fin_init[0] |-> (age0_r == INIT_LAST))
    else $error("initial run length wrong");
  chk_hold_retained: assert property (
    ($fell(en_r[0]) && hold_r[0] && !start_acc[0]) |=> correction_valid[0])
    else $error("correction lost on disable");
  chk_pump_gate: assert property (!ok_run |=> (initial_active == '0 && live_active == '0))
    else $error("servo ran without pump or clock");
  chk_live_start: assert property (
    (g_ch[0].live_acc && !start_acc[0]) |-> s_live_accept)
    else $error("live trigger did not start a series");
  chk_live_count: assert property (
    (g_ch[1].live_acc && !start_acc[1]) |=> (g_ch[1].left_r == ($past(live_len) - 7'h01)))
    else $error("series length loaded wrong");
  chk_done_clear: assert property ((start_acc[1] && !fin_init[1]) |=> !done_r[1])
    else $error("completion not cleared by new trigger");
endmodule
`default_nettype wire

// *** hdl/svo_pkg.sv ***
`default_nettype none
package svo_pkg;
  // timing
  localparam int unsigned CLOCK_HZ            = 10_000_000;
  localparam int unsigned INITIAL_TIME_MS     = 24;
  localparam int unsigned INITIAL_CYCLES      = INITIAL_TIME_MS * (CLOCK_HZ / 1000);
  localparam int unsigned LIVE_UPDATE_TIME_MS = 20;
  localparam int unsigned LIVE_UPDATE_CYCLES  = LIVE_UPDATE_TIME_MS * (CLOCK_HZ / 1000);
  localparam int          CNT_W               = 24;

  // bus geometry
  localparam int          ADDR_W              = 12;
  localparam int          REG_W               = 16;

  // register indices, byte address is four times the index
  localparam logic [7:0]  IDX_INPUT_CTRL      = 8'h3c;
  localparam logic [7:0]  IDX_HP_CTRL         = 8'h3d;
  localparam logic [7:0]  IDX_SERIES_LEN      = 8'h40;
  localparam logic [7:0]  IDX_STATUS          = 8'h42;
  localparam logic [7:0]  IDX_ACTIVITY        = 8'h44;
  localparam logic [7:0]  IDX_IRQ_STATUS      = 8'h45;
  localparam logic [7:0]  IDX_IRQ_MASK        = 8'h46;

  // control register fields; input words share the enable and init bits, live bits are headphone only
  localparam int          BIT_L_EN            = 7;
  localparam int          BIT_L_INIT          = 6;
  localparam int          BIT_L_LIVE          = 4;
  localparam int          BIT_R_EN            = 3;
  localparam int          BIT_R_INIT          = 2;
  localparam int          BIT_R_LIVE          = 0;

  // series length field
  localparam int          LEN_LSB             = 7;
  localparam int          LEN_W               = 7;
  localparam logic [6:0]  LEN_RESET           = 7'h10;
  localparam logic [6:0]  LEN_MIN             = 7'h10;

  // status field, channel c at DONE_LSB + c
  localparam int          DONE_LSB            = 7;

  // channels: 0 hp right, 1 hp left, 2 input right, 3 input left
  localparam int          NUM_CH              = 4;
  localparam int          NUM_LIVE            = 2;
  localparam int          IRQ_W               = 6;
  localparam logic [15:0] REG_RESET           = 16'h0000;

  typedef enum logic [1:0] {CH_IDLE, CH_INITIAL, CH_LIVE} svo_chan_state_t;
endpackage
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import svo_pkg::*;

  // short counts keep the run small
  localparam int unsigned INIT_C = 20;
  localparam int unsigned UPD_C  = 10;

  logic                clock;
  logic                reset_n;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata;
  logic [3:0]          pstrb;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                pump_enable;
  logic                sysclk_present;
  logic [NUM_CH-1:0]   initial_active;
  logic [NUM_LIVE-1:0] live_active;
  logic [NUM_LIVE-1:0] live_update;
  logic [NUM_CH-1:0]   correction_valid;
  logic                irq;
  logic [31:0]         rd;
  logic                err;
  int                  fail_count;
  int                  num_checks;
  int                  pulses;
  int                  pulses1;
  logic [6:0]          codes [3] = '{7'h05, 7'h10, 7'h7f};
  int                  expn  [3] = '{16, 16, 127};

  svo_ctrl #(.INIT_CYC(INIT_C), .UPD_CYC(UPD_C)) svo_ctrl_i (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pump_enable(pump_enable), .sysclk_present(sysclk_present),
    .initial_active(initial_active), .live_active(live_active), .live_update(live_update),
    .correction_valid(correction_valid), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle cycle follows so psel is never driven twice at one edge
  task automatic xfer(input logic [11:0] a, input logic [31:0] d, input logic w);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no local limit: the watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, d, 1'b1);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    xfer(a, 32'h0000_0000, 1'b0);
    chk({31'h0, err}, {31'h0, experr});
    chk(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask

  initial begin
    ticks(30000);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    pump_enable = 1'b0;
    sysclk_present = 1'b0;
    fail_count = 0;
    num_checks = 0;
    ticks(8);
    reset_n <= 1'b1;
    ticks(3);
    rdchk(12'h0f0, 32'h0000_0000, 1'b0);
    rdchk(12'h0f4, 32'h0000_0000, 1'b0);
    rdchk(12'h100, 32'h0000_0800, 1'b0);
    rdchk(12'h108, 32'h0000_0000, 1'b0);
    rdchk(12'h118, 32'h0000_0000, 1'b0);
    rdchk(12'h1fc, 32'h0000_0000, 1'b1);
    rdchk(12'h0f2, 32'h0000_0000, 1'b1);
    // each run condition missing alone must block a trigger
    for (int i = 0; i < 2; i++) begin
      pump_enable <= i[0];
      sysclk_present <= ~i[0];
      ticks(4);
      wr(12'h0f4, 32'h0000_00cc);
      ticks(1);
      chk({28'h0, initial_active}, 32'h0000_0000);
    end
    rdchk(12'h0f4, 32'h0000_0088, 1'b0);
    pump_enable <= 1'b1;
    sysclk_present <= 1'b1;
    ticks(4);
    wr(12'h0f4, 32'h0000_0044);
    ticks(1);
    chk({28'h0, initial_active}, 32'h0000_0000);
    // inputs launched four cycles ahead of the headphones
    wr(12'h0f0, 32'h0000_00cc);
    wr(12'h0f4, 32'h0000_00cc);
    chk({28'h0, initial_active}, 32'h0000_000f);
    ticks(INIT_C - 5);
    chk({28'h0, initial_active}, 32'h0000_000f);
    ticks(1);
    chk({28'h0, initial_active}, 32'h0000_0003);
    ticks(3);
    chk({28'h0, initial_active}, 32'h0000_0003);
    ticks(1);
    chk({28'h0, initial_active}, 32'h0000_0000);
    chk({28'h0, correction_valid}, 32'h0000_000f);
    rdchk(12'h108, 32'h0000_0780, 1'b0);
    rdchk(12'h114, 32'h0000_000f, 1'b0);
    wr(12'h118, 32'h0000_0001);
    ticks(1);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(12'h114, 32'h0000_0001);
    ticks(1);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(12'h114, 32'h0000_000e, 1'b0);
    wr(12'h0f4, 32'h0000_0000);
    ticks(2);
    chk({28'h0, correction_valid}, 32'h0000_000f);
    rdchk(12'h108, 32'h0000_0780, 1'b0);
    wr(12'h0f4, 32'h0000_000c);
    rdchk(12'h108, 32'h0000_0700, 1'b0);
    rdchk(12'h0f4, 32'h0000_0008, 1'b0);
    ticks(INIT_C);
    rdchk(12'h108, 32'h0000_0780, 1'b0);
    wr(12'h114, 32'h0000_003f);
    // input words have no live trigger bits
    wr(12'h0f0, 32'h0000_0099);
    ticks(2);
    chk({26'h0, initial_active, live_active}, 32'h0000_0000);
    rdchk(12'h0f0, 32'h0000_0088, 1'b0);
    wr(12'h118, 32'h0000_0030);
    for (int i = 0; i < 3; i++) begin
      wr(12'h100, {18'h0, codes[i], 7'h00});
      rdchk(12'h100, {18'h0, codes[i], 7'h00}, 1'b0);
      wr(12'h0f4, 32'h0000_0099);
      chk({30'h0, live_active}, 32'h0000_0003);
      rdchk(12'h110, 32'h0000_0030, 1'b0);
      pulses = 0;
      pulses1 = 0;
      repeat (expn[i] * UPD_C + 20) begin
        @(posedge clock);
        pulses += int'(live_update[0]);
        pulses1 += int'(live_update[1]);
      end
      chk(pulses, expn[i]);
      chk(pulses1, expn[i]);
      chk({30'h0, live_active}, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      rdchk(12'h114, 32'h0000_0030, 1'b0);
      wr(12'h114, 32'h0000_0030);
      ticks(1);
      chk({31'h0, irq}, 32'h0000_0000);
    end
    // a live trigger during an initial run is refused
    wr(12'h0f4, 32'h0000_00cc);
    wr(12'h0f4, 32'h0000_0099);
    chk({26'h0, initial_active, live_active}, 32'h0000_000c);
    rdchk(12'h108, 32'h0000_0600, 1'b0);
    ticks(INIT_C);
    chk({26'h0, initial_active, live_active}, 32'h0000_0000);
    rdchk(12'h108, 32'h0000_0780, 1'b0);
    // reset in the middle of a live series
    wr(12'h0f4, 32'h0000_0099);
    chk({30'h0, live_active}, 32'h0000_0003);
    reset_n <= 1'b0;
    ticks(2);
    chk({21'h0, irq, correction_valid, initial_active, live_active}, 32'h0000_0000);
    reset_n <= 1'b1;
    ticks(3);
    rdchk(12'h100, 32'h0000_0800, 1'b0);
    rdchk(12'h0f4, 32'h0000_0000, 1'b0);
    rdchk(12'h108, 32'h0000_0000, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
